// ==== src/bstr_pkg.sv ====
// Shared constants and types for the boundary-scan test access block
package bstr_pkg;

    // Register lengths
    localparam int INS_W = 8;
    localparam int BND_W = 38;
    localparam int CTL_W = 11;
    localparam int LANES = 8;
    localparam int CTL_OP_W = 3;

    // Reset and capture values
    localparam logic [INS_W-1:0] INS_RESET = 8'hFF;
    localparam logic [INS_W-1:0] INS_CAPTURE = 8'h81;
    localparam logic [BND_W-1:0] BND_RESET = 38'h30_0000_0000;
    localparam logic [CTL_W-1:0] CTL_RESET = 11'h002;
    localparam logic BYPASS_CAPTURE = 1'b0;

    // Field positions
    localparam int INS_PARITY_BIT = 7;
    localparam int BND_A_TO_B_OUTPUT_ENABLE_BIT = 37;
    localparam int BND_A_IN_MSB = 31;
    localparam int BND_B_IN_MSB = 15;
    localparam int CTL_INPUT_MASK_LANE1_BIT = 3;
    localparam int CTL_TEST_OP_BIT2 = 2;

    // Mode select cycles that always reach test-logic-reset
    localparam int TMS_RESET_CYCLES = 5;

    // Implemented instruction codes, bit 7 already holds even parity
    localparam logic [INS_W-1:0] OP_BOUNDARY_SCAN_A = 8'h00;
    localparam logic [INS_W-1:0] OP_SAMPLE_BOUNDARY = 8'h82;
    localparam logic [INS_W-1:0] OP_BOUNDARY_SCAN_B = 8'h03;
    localparam logic [INS_W-1:0] OP_HIGH_IMPEDANCE = 8'h06;
    localparam logic [INS_W-1:0] OP_CLAMP_BOUNDARY = 8'h87;
    localparam logic [INS_W-1:0] OP_BOUNDARY_RUN_TEST = 8'h09;
    localparam logic [INS_W-1:0] OP_READ_NORMAL = 8'h0A;
    localparam logic [INS_W-1:0] OP_READ_TEST = 8'h8B;
    localparam logic [INS_W-1:0] OP_CELL_SELF_TEST = 8'h0C;
    localparam logic [INS_W-1:0] OP_TOGGLE_OUTPUTS = 8'h8D;
    localparam logic [INS_W-1:0] OP_CONTROL_SCAN_NORMAL = 8'h8E;
    localparam logic [INS_W-1:0] OP_CONTROL_SCAN_TEST = 8'h0F;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
        ST_UPD_DR, ST_SEL_INS, ST_CAP_INS, ST_SH_INS, ST_EX1_INS, ST_PAU_INS, ST_EX2_INS,
        ST_UPD_INS
    } bstr_tap_state_t;

    typedef enum logic [1:0] {
        SEL_BYPASS, SEL_BOUNDARY, SEL_CONTROL
    } bstr_dr_sel_t;

    // Packed in boundary chain order, bit 37 first
    typedef struct packed {
        logic a_to_b_output_enable;
        logic b_to_a_output_enable;
        logic a_to_b_clock;
        logic b_to_a_clock;
        logic a_to_b_clock_enable;
        logic b_to_a_clock_enable;
        logic [LANES-1:0] a_in;
        logic [LANES-1:0] a_out;
        logic [LANES-1:0] b_in;
        logic [LANES-1:0] b_out;
    } bstr_boundary_cells_t;

    typedef struct packed {
        logic [LANES-1:0] input_mask;
        logic [CTL_OP_W-1:0] test_op;
    } bstr_test_control_t;

endpackage

// ==== src/bstr_tap.sv ====
// Test access port state machine with instruction, boundary, control and bypass registers
//
// Function
// - Exit states may return to shifting without recapturing the register.
// - First falling edge after data exit-1 entry turns the serial output off.
// - Data pause holds indefinitely, does nothing, keeps shifted data.
// - Data update loads shadow latches on falling edge when instruction calls for it.
// - Instruction capture loads 10000001 on the edge leaving capture.
// - Instruction shift drives output from the instruction LSB after first falling edge.
// - Instruction shifts once per rising edge, including the leaving edge.
// - First falling edge after instruction exit-1 entry turns the output off.
// - Instruction pause holds indefinitely and keeps the shifted bits.
// - Instruction update latches shifted value on falling edge, making it active.
// - Each register has shift stage and shadow latch, except bypass.
// - Eight-bit instruction selects mode, operation, data register and capture source.
// - Bit 7 is even parity; unimplemented codes act as bypass.
// - Power-up and test-logic-reset set instruction to 11111111, bypass.
// - Boundary chain holds 38 cells, two per bidirectional pin.
// - Boundary cells reset to 0 except cells 37 and 36 set to 1.
// - Boundary chain shifts input through bits 37 to 0; capture source by instruction (here every boundary code captures synchronised pin levels).
// - Bits 37-32 enables, clocks, clock enables; then A in/out, B in/out.
// - Control register is 11 bits selecting extended run-test operations.
// - Data capture leaves the control register unchanged.
// - Control register resets to 00000000010, unmasked signature analysis.
// - Control shifts through bits 10 to 0; bits 10-3 masks, 2-0 opcode.
// - State advances on mode select sampled at each rising test clock edge.
// - Mode select high for five cycles reaches test-logic-reset from anywhere.
// - Bypass register captures 0 during data capture.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`default_nettype none

module bstr_tap (
    input wire logic clock,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    input wire bstr_pkg::bstr_boundary_cells_t pin_levels,
    output bstr_pkg::bstr_boundary_cells_t boundary_cells,
    output bstr_pkg::bstr_test_control_t boundary_test_control,
    output logic [bstr_pkg::INS_W-1:0] instruction_register,
    output bstr_pkg::bstr_tap_state_t tap_state,
    output logic test_mode
);
    import bstr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction decode

    function automatic bstr_dr_sel_t decode_select(input logic [INS_W-1:0] op);
        bstr_dr_sel_t sel;
        sel = SEL_BYPASS;
        case (op)
            OP_BOUNDARY_SCAN_A, OP_SAMPLE_BOUNDARY, OP_BOUNDARY_SCAN_B,
            OP_READ_NORMAL, OP_READ_TEST, OP_CELL_SELF_TEST: begin
                sel = SEL_BOUNDARY;
            end
            OP_CONTROL_SCAN_NORMAL, OP_CONTROL_SCAN_TEST: begin
                sel = SEL_CONTROL;
            end
            // Full 8-bit match, so a code with wrong parity or no function falls to bypass
            default: begin
                sel = SEL_BYPASS;
            end
        endcase
        return sel;
    endfunction

    function automatic logic decode_test_mode(input logic [INS_W-1:0] op);
        logic tm;
        tm = 1'b0;
        case (op)
            OP_BOUNDARY_SCAN_A, OP_BOUNDARY_SCAN_B, OP_HIGH_IMPEDANCE, OP_CLAMP_BOUNDARY,
            OP_BOUNDARY_RUN_TEST, OP_READ_TEST, OP_TOGGLE_OUTPUTS, OP_CONTROL_SCAN_TEST: begin
                tm = 1'b1;
            end
            default: begin
                tm = 1'b0;
            end
        endcase
        return tm;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Controller state, rising edge

    bstr_tap_state_t state_reg;
    bstr_tap_state_t state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: state_next = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: state_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_next = tms ? ST_SEL_INS : ST_CAP_DR;
            ST_CAP_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_next = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_next = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_INS: state_next = tms ? ST_RESET : ST_CAP_INS;
            ST_CAP_INS: state_next = tms ? ST_EX1_INS : ST_SH_INS;
            ST_SH_INS: state_next = tms ? ST_EX1_INS : ST_SH_INS;
            ST_EX1_INS: state_next = tms ? ST_UPD_INS : ST_PAU_INS;
            ST_PAU_INS: state_next = tms ? ST_EX2_INS : ST_PAU_INS;
            ST_EX2_INS: state_next = tms ? ST_UPD_INS : ST_SH_INS;
            ST_UPD_INS: state_next = tms ? ST_SEL_DR : ST_IDLE;
            default: state_next = ST_RESET;
        endcase
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin levels arrive from outside the test clock domain

    bstr_boundary_cells_t pin_meta_reg;
    bstr_boundary_cells_t pin_sync_reg;

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= pin_levels;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shift stages, rising edge

    logic [INS_W-1:0] ins_shift_reg;
    logic [INS_W-1:0] ins_shift_next;
    logic [BND_W-1:0] bnd_shift_reg;
    logic [BND_W-1:0] bnd_shift_next;
    logic [CTL_W-1:0] ctl_shift_reg;
    logic [CTL_W-1:0] ctl_shift_next;
    logic bypass_reg;
    logic bypass_next;
    logic [INS_W-1:0] ins_active_reg;
    bstr_dr_sel_t dr_sel;

    // Active instruction changes only on falling edges, so it is steady here
    assign dr_sel = decode_select(ins_active_reg);

    always_comb begin
        ins_shift_next = ins_shift_reg;
        bnd_shift_next = bnd_shift_reg;
        ctl_shift_next = ctl_shift_reg;
        bypass_next = bypass_reg;
        case (state_reg)
            ST_RESET: begin
                ins_shift_next = INS_RESET;
                bnd_shift_next = BND_RESET;
                ctl_shift_next = CTL_RESET;
                bypass_next = BYPASS_CAPTURE;
            end
            ST_CAP_INS: begin
                ins_shift_next = INS_CAPTURE;
            end
            ST_SH_INS: begin
                ins_shift_next = {tdi, ins_shift_reg[INS_W-1:1]};
            end
            ST_CAP_DR: begin
                // Control stage is left alone on capture
                if (dr_sel == SEL_BOUNDARY) begin
                    bnd_shift_next = pin_sync_reg;
                end
                if (dr_sel == SEL_BYPASS) begin
                    bypass_next = BYPASS_CAPTURE;
                end
            end
            ST_SH_DR: begin
                if (dr_sel == SEL_BOUNDARY) begin
                    bnd_shift_next = {tdi, bnd_shift_reg[BND_W-1:1]};
                end
                if (dr_sel == SEL_CONTROL) begin
                    ctl_shift_next = {tdi, ctl_shift_reg[CTL_W-1:1]};
                end
                if (dr_sel == SEL_BYPASS) begin
                    bypass_next = tdi;
                end
            end
            // Exit and pause states keep partial contents for a later resume
            default: begin
                ins_shift_next = ins_shift_reg;
            end
        endcase
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            ins_shift_reg <= INS_RESET;
            bnd_shift_reg <= BND_RESET;
            ctl_shift_reg <= CTL_RESET;
            bypass_reg <= BYPASS_CAPTURE;
        end else begin
            ins_shift_reg <= ins_shift_next;
            bnd_shift_reg <= bnd_shift_next;
            ctl_shift_reg <= ctl_shift_next;
            bypass_reg <= bypass_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shadow latches and serial output, falling edge

    logic [INS_W-1:0] ins_active_next;
    logic [BND_W-1:0] bnd_shadow_reg;
    logic [BND_W-1:0] bnd_shadow_next;
    logic [CTL_W-1:0] ctl_shadow_reg;
    logic [CTL_W-1:0] ctl_shadow_next;
    logic tdo_reg;
    logic tdo_next;
    logic tdo_oe_n_reg;
    logic tdo_oe_n_next;
    logic test_mode_tck_reg;
    logic test_mode_tck_next;

    always_comb begin
        ins_active_next = ins_active_reg;
        bnd_shadow_next = bnd_shadow_reg;
        ctl_shadow_next = ctl_shadow_reg;
        tdo_next = tdo_reg;
        tdo_oe_n_next = 1'b1;
        case (state_reg)
            ST_RESET: begin
                ins_active_next = INS_RESET;
                bnd_shadow_next = BND_RESET;
                ctl_shadow_next = CTL_RESET;
            end
            ST_UPD_INS: begin
                ins_active_next = ins_shift_reg;
            end
            ST_UPD_DR: begin
                // Bypass has no shadow, so nothing latches for it
                if (dr_sel == SEL_BOUNDARY) begin
                    bnd_shadow_next = bnd_shift_reg;
                end
                if (dr_sel == SEL_CONTROL) begin
                    ctl_shadow_next = ctl_shift_reg;
                end
            end
            ST_SH_INS: begin
                tdo_next = ins_shift_reg[0];
                tdo_oe_n_next = 1'b0;
            end
            ST_SH_DR: begin
                tdo_oe_n_next = 1'b0;
                case (dr_sel)
                    SEL_BOUNDARY: tdo_next = bnd_shift_reg[0];
                    SEL_CONTROL: tdo_next = ctl_shift_reg[0];
                    default: tdo_next = bypass_reg;
                endcase
            end
            default: begin
                tdo_next = tdo_reg;
            end
        endcase
        test_mode_tck_next = decode_test_mode(ins_active_next);
    end

    always_ff @(negedge tck or posedge rst) begin
        if (rst) begin
            ins_active_reg <= INS_RESET;
            bnd_shadow_reg <= BND_RESET;
            ctl_shadow_reg <= CTL_RESET;
            tdo_reg <= 1'b0;
            tdo_oe_n_reg <= 1'b1;
            test_mode_tck_reg <= 1'b0;
        end else begin
            ins_active_reg <= ins_active_next;
            bnd_shadow_reg <= bnd_shadow_next;
            ctl_shadow_reg <= ctl_shadow_next;
            tdo_reg <= tdo_next;
            tdo_oe_n_reg <= tdo_oe_n_next;
            test_mode_tck_reg <= test_mode_tck_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode flag into the system clock domain, a level through two flops

    logic test_mode_meta_reg;
    logic test_mode_sync_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            test_mode_meta_reg <= 1'b0;
            test_mode_sync_reg <= 1'b0;
        end else begin
            test_mode_meta_reg <= test_mode_tck_reg;
            test_mode_sync_reg <= test_mode_meta_reg;
        end
    end

    assign tdo = tdo_reg;
    assign tdo_oe_n = tdo_oe_n_reg;
    assign boundary_cells = bnd_shadow_reg;
    assign boundary_test_control = ctl_shadow_reg;
    assign instruction_register = ins_active_reg;
    assign tap_state = state_reg;
    assign test_mode = test_mode_sync_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_tms_held_high;
        tms [*5];
    endsequence

    property p_reset_in_five;
        @(posedge tck) disable iff (rst)
        s_tms_held_high |=> (state_reg == ST_RESET);
    endproperty
    a_reset_in_five: assert property (p_reset_in_five) else $error("not in reset after five");

    property p_capture_ins;
        @(posedge tck) disable iff (rst)
        (state_reg == ST_CAP_INS) && !tms ##1 (state_reg == ST_SH_INS)
            |-> (ins_shift_reg == INS_CAPTURE);
    endproperty
    a_capture_ins: assert property (p_capture_ins) else $error("capture pattern wrong");

    property p_ins_shift;
        @(posedge tck) disable iff (rst)
        (state_reg == ST_SH_INS)
            |=> (ins_shift_reg == {$past(tdi), $past(ins_shift_reg[INS_W-1:1])});
    endproperty
    a_ins_shift: assert property (p_ins_shift) else $error("instruction shift wrong");

    property p_ins_pause;
        @(posedge tck) disable iff (rst)
        (state_reg == ST_PAU_INS) |=> $stable(ins_shift_reg);
    endproperty
    a_ins_pause: assert property (p_ins_pause) else $error("instruction pause lost data");

    property p_dr_pause;
        @(posedge tck) disable iff (rst)
        (state_reg == ST_PAU_DR) |=> $stable(bnd_shift_reg) && $stable(ctl_shift_reg);
    endproperty
    a_dr_pause: assert property (p_dr_pause) else $error("data pause lost data");

    property p_ctl_capture;
        @(posedge tck) disable iff (rst)
        (state_reg == ST_CAP_DR) |=> $stable(ctl_shift_reg);
    endproperty
    a_ctl_capture: assert property (p_ctl_capture) else $error("control changed on capture");

    property p_bypass_capture;
        @(posedge tck) disable iff (rst)
        (state_reg == ST_CAP_DR) && (dr_sel == SEL_BYPASS) |=> (bypass_reg == 1'b0);
    endproperty
    a_bypass_capture: assert property (p_bypass_capture) else $error("bypass not zero");

    property p_exit_dr_off;
        @(negedge tck) disable iff (rst)
        (state_reg == ST_EX1_DR) |=> tdo_oe_n_reg;
    endproperty
    a_exit_dr_off: assert property (p_exit_dr_off) else $error("output on after data exit");

    property p_exit_ins_off;
        @(negedge tck) disable iff (rst)
        (state_reg == ST_EX1_INS) |=> tdo_oe_n_reg;
    endproperty
    a_exit_ins_off: assert property (p_exit_ins_off) else $error("output on after instr exit");

    property p_shift_ins_drive;
        @(negedge tck) disable iff (rst)
        (state_reg == ST_SH_INS) |=> !tdo_oe_n_reg && (tdo_reg == $past(ins_shift_reg[0]));
    endproperty
    a_shift_ins_drive: assert property (p_shift_ins_drive) else $error("shift output wrong");

    property p_update_ins;
        @(negedge tck) disable iff (rst)
        (state_reg == ST_UPD_INS) |=> (ins_active_reg == $past(ins_shift_reg));
    endproperty
    a_update_ins: assert property (p_update_ins) else $error("instruction not updated");

    property p_tlr_values;
        @(negedge tck) disable iff (rst)
        (state_reg == ST_RESET) |=> (ins_active_reg == INS_RESET)
            && (ctl_shadow_reg == CTL_RESET) && (bnd_shadow_reg == BND_RESET);
    endproperty
    a_tlr_values: assert property (p_tlr_values) else $error("reset values wrong");

    property p_idle_off;
        @(negedge tck) disable iff (rst)
        (state_reg != ST_SH_INS) && (state_reg != ST_SH_DR) |=> tdo_oe_n_reg;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("output on outside shift");

endmodule

`default_nettype wire

// ==== tb/bstr_ctl_model.sv ====
// Behavioural board test controller driving the four-wire scan port
`timescale 1ns/1ns
`default_nettype none

module bstr_ctl_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n,
    output logic scan_done,
    output logic [63:0] scan_out,
    output logic oe_fault
);
    logic tdo_seen;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        scan_done = 1'b0;
        scan_out = '0;
        oe_fault = 1'b0;
        tdo_seen = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One test clock period; mode and data change only while the clock is low
    task automatic step(input logic m, input logic d, input logic oe_exp);
        tms = m;
        tdi = d;
        #24;
        tdo_seen = tdo;
        if (tdo_oe_n !== oe_exp) begin
            oe_fault = 1'b1;
        end
        tck = 1'b1;
        #24;
        tck = 1'b0;
    endtask

    // Mode select held high; three edges suffice from idle, five are given
    task automatic tlr();
        repeat (5) step(1'b1, 1'b1, 1'b1);
        tdi = 1'b1;
    endtask

    // Full scan from idle back to idle; pause_at below zero means no pause
    task automatic scan(input logic is_ins, input int len, input logic [63:0] din,
                        input int pause_at);
        logic [63:0] dout;
        dout = '0;
        // Idle cycles give the pin synchroniser time before a capture
        step(1'b0, 1'b1, 1'b1);
        step(1'b0, 1'b1, 1'b1);
        step(1'b1, 1'b1, 1'b1);
        if (is_ins) begin
            step(1'b1, 1'b1, 1'b1);
        end
        step(1'b0, 1'b1, 1'b1);
        step(1'b0, 1'b1, 1'b1);
        for (int i = 0; i < len; i++) begin
            step((i == len - 1) || (i == pause_at), din[i], 1'b0);
            dout[i] = tdo_seen;
            if (i == pause_at && i != len - 1) begin
                // Park in pause, then back to shift through exit-2 with no recapture
                repeat (6) step(1'b0, 1'b1, 1'b1);
                step(1'b1, 1'b1, 1'b1);
                step(1'b0, 1'b1, 1'b1);
            end
        end
        step(1'b1, 1'b1, 1'b1);
        step(1'b0, 1'b1, 1'b1);
        // Released lines float high through the pull-ups
        tms = 1'b1;
        tdi = 1'b1;
        scan_out = dout;
        scan_done = 1'b1;
        #1;
        scan_done = 1'b0;
    endtask
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the scan test access block
`timescale 1ns/1ns
`default_nettype none

module tb;
    import bstr_pkg::*;
    logic clock, rst, tck, tms, tdi, tdo, tdo_oe_n, test_mode, scan_done, oe_fault;
    logic [63:0] scan_out, rnd;
    logic [37:0] v;
    logic [10:0] w, w2;
    logic [1:0] d;
    bstr_boundary_cells_t pin_levels, boundary_cells;
    bstr_test_control_t boundary_test_control;
    logic [INS_W-1:0] instruction_register;
    bstr_tap_state_t tap_state;
    logic [63:0] exp_q[$];
    int err_total = 0;
    int check_count = 0;
    localparam logic [7:0] OPS [18] = '{8'h00, 8'h81, 8'h82, 8'h03, 8'h84, 8'h05, 8'h06,
        8'h87, 8'h88, 8'h09, 8'h0A, 8'h8B, 8'h0C, 8'h8D, 8'h8E, 8'h0F, 8'h01, 8'hFF};
    localparam bit [0:17] BND = 18'b101100000011100000;
    localparam bit [0:17] CTL = 18'b000000000000001100;
    localparam bit [0:17] MODE = 18'b100100110101010100;

    initial clock = 1'b0;
    always #50 clock = ~clock;

    bstr_tap u_dut (.clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .pin_levels(pin_levels), .boundary_cells(boundary_cells),
        .boundary_test_control(boundary_test_control),
        .instruction_register(instruction_register), .tap_state(tap_state),
        .test_mode(test_mode));

    bstr_ctl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .scan_done(scan_done), .scan_out(scan_out), .oe_fault(oe_fault));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Every scan result is matched against the oldest note, or against all ones when no note is queued
    always @(posedge scan_done) begin
        if (exp_q.size() == 0) begin
            check(scan_out, 64'hFFFF_FFFF_FFFF_FFFF);
        end else begin
            check(scan_out, exp_q.pop_front());
        end
    end

    task automatic load_ins(input logic [7:0] op, input int pause_at);
        exp_q.push_back(64'h81);
        u_ctl.scan(1'b1, 8, {56'h0, op}, pause_at);
        check({56'h0, instruction_register}, {56'h0, op});
    endtask

    // Mode flag crosses into the system clock domain; bounded wait
    task automatic wait_mode(input logic exp);
        int n;
        n = 0;
        while (test_mode !== exp && n < 8) begin
            @(negedge clock);
            n++;
        end
        check({63'h0, test_mode}, {63'h0, exp});
        if (test_mode !== exp) begin
            complete_run();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        pin_levels = '0;
        void'($urandom(30957));
        repeat (8) @(negedge clock);
        rst = 1'b0;
        check({56'h0, instruction_register}, 64'hFF);
        check({26'h0, boundary_cells}, {26'h0, 2'b11, 36'h0});
        check({53'h0, boundary_test_control}, {53'h0, 11'b00000000010});
        wait_mode(1'b0);
        // Control register: capture keeps content, shift with a pause, update
        load_ins(8'h8E, 3);
        w = 11'($urandom);
        w2 = 11'($urandom);
        exp_q.push_back(64'h002);
        u_ctl.scan(1'b0, 11, {53'h0, w}, 5);
        check({53'h0, boundary_test_control}, {53'h0, w});
        check({61'h0, boundary_test_control.test_op}, {61'h0, w[2:0]});
        check({56'h0, boundary_test_control.input_mask},
            {56'h0, w[CTL_W-1:CTL_INPUT_MASK_LANE1_BIT]});
        exp_q.push_back({53'h0, w});
        u_ctl.scan(1'b0, 11, {53'h0, w2}, -1);
        check({53'h0, boundary_test_control}, {53'h0, w2});
        // Boundary chain: capture pins, shift 38 bits with a pause, update shadows
        @(negedge clock);
        rnd = {$urandom, $urandom};
        pin_levels = rnd[37:0];
        load_ins(8'h00, -1);
        wait_mode(1'b1);
        rnd = {$urandom, $urandom};
        v = rnd[37:0];
        exp_q.push_back({26'h0, pin_levels});
        u_ctl.scan(1'b0, 38, {26'h0, v}, 20);
        check({26'h0, boundary_cells}, {26'h0, v});
        check({56'h0, boundary_cells.a_in}, {56'h0, v[BND_A_IN_MSB -: LANES]});
        check({56'h0, boundary_cells.b_in}, {56'h0, v[BND_B_IN_MSB -: LANES]});
        // Every listed code, plus codes outside the set that fall back to bypass
        for (int k = 0; k < 18; k++) begin
            load_ins(OPS[k], -1);
            wait_mode(MODE[k]);
            if (!CTL[k]) begin
                d = 2'($urandom);
                exp_q.push_back(BND[k] ? {62'h0, pin_levels[1:0]} : {62'h0, d[0], 1'b0});
                u_ctl.scan(1'b0, 2, {62'h0, d}, -1);
            end
        end
        // Mode select held high restores every reset value
        load_ins(8'h0F, -1);
        u_ctl.tlr();
        check({60'h0, tap_state}, {60'h0, ST_RESET});
        check({56'h0, instruction_register}, 64'hFF);
        check({26'h0, boundary_cells}, {26'h0, 2'b11, 36'h0});
        check({53'h0, boundary_test_control}, {53'h0, 11'b00000000010});
        wait_mode(1'b0);
        check({63'h0, oe_fault}, 64'h0);
        check(64'(exp_q.size()), 64'h0);
        complete_run();
    end
endmodule

`default_nettype wire
